//--- pkg/sram_link_pkg.sv
// Shared constants for the burst-of-four DDR static memory link
package sram_link_pkg;
  // ---------------------------------------------------------------
  // Geometry defaults
  // ---------------------------------------------------------------
  localparam int BURST_LEN  = 4;
  localparam int ADDR_W_DEF = 18;
  localparam int DATA_W_DEF = 36;
  localparam int BYTE_N_DEF = 4;
  // ---------------------------------------------------------------
  // Pipeline taps (edges of the true link clock after a command; CT_WSH_W in system clock cycles)
  // ---------------------------------------------------------------
  localparam int RD_LOAD_TAP  = 1;
  localparam int RD_EARLY_TAP = 2;
  localparam int RD_LATE_TAP  = 3;
  localparam int WR_SH_W      = 3;
  localparam int CT_WSH_W     = 6;
  // ---------------------------------------------------------------
  // Controller timing
  // ---------------------------------------------------------------
  localparam int LINK_RST_CYCLES = 16;
  localparam int INIT_CNT_W      = 5;
endpackage : sram_link_pkg

//--- pkg/sram_link_if.sv
// Link between the memory controller and the burst-of-four memory
`timescale 1ns/1ps
interface sram_link_if #(
  parameter int AW = 18,
  parameter int DW = 36,
  parameter int BN = 4
);
  logic          k;
  logic          rst;
  logic          loop_off_n;
  logic [AW-1:0] sync_address;
  logic          rd_n;
  logic          wr_n;
  logic [DW-1:0] d;
  logic [BN-1:0] byte_write_en_n;
  logic [DW-1:0] q;
  logic          read_valid_out;
  logic          echo_clk_true;
  logic          echo_clk_comp;

  modport ctrl (
    output k, rst, loop_off_n, sync_address, rd_n, wr_n, d, byte_write_en_n,
    input  q, read_valid_out, echo_clk_true, echo_clk_comp
  );
  modport mem (
    input  k, rst, loop_off_n, sync_address, rd_n, wr_n, d, byte_write_en_n,
    output q, read_valid_out, echo_clk_true, echo_clk_comp
  );
endinterface : sram_link_if

//--- design/sram_burst_mem.sv
// Memory end: burst-of-four DDR static memory on the link clock
// Operation
// - Address and selects taken on true rising edge
// - Read and write addresses alternate across edges
// - Beats one and three sampled on true edge
// - Beats two and four sampled on complement edge
// - Only enabled bytes of each beat change
// - Controller drives first beat one cycle later
// - Write spans two cycles, four beats
// - Beats one, three from complement edges, 2.5 latency
// - Beats two, four on third, fourth true edges
// - Read spans two cycles on output bus
// - Every burst is exactly four beats
// - Separate input and output data buses
// - Echo clocks aligned with read launch
// - True edge starts ops, rest self-timed
// - Valid flag marks read data, echo-aligned
// - Echo clocks run free always
// - Loop-disable low selects reduced read latency
// - Address ignored when nothing selected
`timescale 1ns/1ps
module sram_burst_mem
  import sram_link_pkg::*;
#(
  parameter int AW = ADDR_W_DEF,
  parameter int DW = DATA_W_DEF,
  parameter int BN = BYTE_N_DEF
) (
  // Link to the controller
  sram_link_if.mem LINK,
  // Status
  output logic     O_LOOP_BYPASS
);
  localparam int BW = DW / BN;
  localparam int WW = BURST_LEN * DW;
  localparam int MW = BURST_LEN * BN;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]         rst_sync;
    logic [1:0]         loop_sync;
    logic               rd_last;
    logic               wr_last;
    logic [AW-1:0]      rd_addr;
    logic [3:0]         rd_sh;
    logic [AW-1:0]      wr_cmd_addr;
    logic [AW-1:0]      wr_buf_addr;
    logic [WR_SH_W-1:0] wr_sh;
    logic [DW-1:0]      wb0;
    logic [DW-1:0]      wb2;
    logic [BN-1:0]      be0;
    logic [BN-1:0]      be2;
    logic [WW-1:0]      rword;
    logic [DW-1:0]      q_pos;
    logic               vld_pos;
  } pos_s;

  typedef struct packed {
    logic [DW-1:0] wb1;
    logic [DW-1:0] wb3;
    logic [BN-1:0] be1;
    logic [BN-1:0] be3;
    logic [DW-1:0] q_neg;
    logic          vld_neg;
  } neg_s;

  pos_s          p_reg;
  pos_s          p_next;
  neg_s          n_reg;
  neg_s          n_next;
  logic [WW-1:0] mem [2**AW];
  logic          commit;
  logic [WW-1:0] commit_word;
  logic [WW-1:0] fetch_word;
  logic          rst;
  logic          bypass;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // byte merge
  function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_w,
                                          input logic [WW-1:0] new_w,
                                          input logic [MW-1:0] en);
    logic [WW-1:0] res;
    res = old_w;
    for (int i = 0; i < MW; i++) begin
      if (en[i]) begin
        res[i*BW +: BW] = new_w[i*BW +: BW];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [DW-1:0] beat(input logic [WW-1:0] w, input int idx);
    return w[idx*DW +: DW];
  endfunction : beat

  assign rst    = p_reg.rst_sync[1];
  assign bypass = ~p_reg.loop_sync[1];

  // ---------------------------------------------------------------
  // True-edge logic
  // ---------------------------------------------------------------
  always_comb begin
    logic          rd_go;
    logic          wr_go;
    logic [MW-1:0] seen;
    rd_go  = 1'b0;
    wr_go  = 1'b0;
    seen   = '0;
    p_next = p_reg;
    p_next.rst_sync  = {p_reg.rst_sync[0], LINK.rst};
    p_next.loop_sync = {p_reg.loop_sync[0], LINK.loop_off_n};

    // command capture; read and write alternate per channel
    rd_go = ~LINK.rd_n & ~p_reg.rd_last;
    // shared address: a read on this edge pushes the write out
    wr_go = ~LINK.wr_n & ~p_reg.wr_last & ~rd_go;
    p_next.rd_last = rd_go;
    p_next.wr_last = wr_go;
    // address only taken with a select
    if (rd_go) begin
      p_next.rd_addr = LINK.sync_address;
    end
    if (wr_go) begin
      p_next.wr_cmd_addr = LINK.sync_address;
    end
    p_next.rd_sh = {p_reg.rd_sh[2:0], rd_go};
    p_next.wr_sh = {p_reg.wr_sh[WR_SH_W-2:0], wr_go};

    // beats one and three on the true edge
    if (p_reg.wr_sh[0]) begin
      p_next.wr_buf_addr = p_reg.wr_cmd_addr;
      p_next.wb0         = LINK.d;
      p_next.be0         = ~LINK.byte_write_en_n;
    end
    if (p_reg.wr_sh[1]) begin
      p_next.wb2 = LINK.d;
      p_next.be2 = ~LINK.byte_write_en_n;
    end

    // buffered write beats override the array on fetch
    if (p_reg.wr_sh[WR_SH_W-1]) begin
      seen = '1;
    end else if (p_reg.wr_sh[1]) begin
      seen = {{(2*BN){1'b0}}, {(2*BN){1'b1}}};
    end
    fetch_word = mem[p_reg.rd_addr];
    if (p_reg.wr_buf_addr == p_reg.rd_addr) begin
      fetch_word = merge(fetch_word, {n_reg.wb3, p_reg.wb2, n_reg.wb1, p_reg.wb0},
                         seen & {n_reg.be3, p_reg.be2, n_reg.be1, p_reg.be0});
    end
    if (p_reg.rd_sh[RD_LOAD_TAP]) begin
      p_next.rword = fetch_word;
    end

    // true-edge launch; bypass moves beats earlier
    p_next.vld_pos = 1'b0;
    if (bypass) begin
      if (p_reg.rd_sh[RD_LOAD_TAP]) begin
        p_next.q_pos   = beat(fetch_word, 0);
        p_next.vld_pos = 1'b1;
      end else if (p_reg.rd_sh[RD_EARLY_TAP]) begin
        p_next.q_pos   = beat(p_reg.rword, 2);
        p_next.vld_pos = 1'b1;
      end
    end else begin
      if (p_reg.rd_sh[RD_EARLY_TAP]) begin
        p_next.q_pos   = beat(p_reg.rword, 1);
        p_next.vld_pos = 1'b1;
      end else if (p_reg.rd_sh[RD_LATE_TAP]) begin
        p_next.q_pos   = beat(p_reg.rword, 3);
        p_next.vld_pos = 1'b1;
      end
    end

    // write commits once all four beats are held
    commit      = p_reg.wr_sh[WR_SH_W-1] & ~rst;
    commit_word = merge(mem[p_reg.wr_buf_addr],
                        {n_reg.wb3, p_reg.wb2, n_reg.wb1, p_reg.wb0},
                        {n_reg.be3, p_reg.be2, n_reg.be1, p_reg.be0});

    if (rst) begin
      p_next.rd_last = 1'b0;
      p_next.wr_last = 1'b0;
      p_next.rd_sh   = '0;
      p_next.wr_sh   = '0;
      p_next.q_pos   = '0;
      p_next.vld_pos = 1'b0;
    end
  end

  always_ff @(posedge LINK.k) begin
    p_reg <= p_next;
  end

  // Array write; only the addressed word is touched
  always_ff @(posedge LINK.k) begin
    if (commit) begin
      mem[p_reg.wr_buf_addr] <= commit_word;
    end
  end

  // ---------------------------------------------------------------
  // Complement-edge logic
  // ---------------------------------------------------------------
  always_comb begin
    n_next = n_reg;
    // beats two and four on the complement edge
    if (p_reg.wr_sh[1]) begin
      n_next.wb1 = LINK.d;
      n_next.be1 = ~LINK.byte_write_en_n;
    end
    if (p_reg.wr_sh[2]) begin
      n_next.wb3 = LINK.d;
      n_next.be3 = ~LINK.byte_write_en_n;
    end
    // beats one and three from the complement edge, two and four with bypass
    n_next.vld_neg = p_reg.rd_sh[RD_EARLY_TAP] | p_reg.rd_sh[RD_LATE_TAP];
    if (p_reg.rd_sh[RD_EARLY_TAP]) begin
      n_next.q_neg = beat(p_reg.rword, bypass ? 1 : 0);
    end else if (p_reg.rd_sh[RD_LATE_TAP]) begin
      n_next.q_neg = beat(p_reg.rword, bypass ? 3 : 2);
    end
    if (rst) begin
      n_next.vld_neg = 1'b0;
      n_next.q_neg   = '0;
    end
  end

  // Complement clock is the inverse of the true one on this link
  always_ff @(negedge LINK.k) begin
    n_reg <= n_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // dedicated read bus; valid follows the same half-cycle mux
  assign LINK.q              = LINK.k ? p_reg.q_pos : n_reg.q_neg;
  assign LINK.read_valid_out = LINK.k ? p_reg.vld_pos : n_reg.vld_neg;
  // echo clocks follow the input clock and never stop
  assign LINK.echo_clk_true = LINK.k;
  assign LINK.echo_clk_comp = ~LINK.k;
  assign O_LOOP_BYPASS      = bypass;

endmodule : sram_burst_mem

//--- design/sram_burst_ctrl.sv
// Controller end: drives the burst-of-four memory link from the system clock
`timescale 1ns/1ps
module sram_burst_ctrl
  import sram_link_pkg::*;
#(
  parameter int AW = ADDR_W_DEF,
  parameter int DW = DATA_W_DEF,
  parameter int BN = BYTE_N_DEF
) (
  // Clock and reset
  input  wire logic                    I_CLK_SYS,
  input  wire logic                    I_SYS_RST,
  // Mode
  input  wire logic                    I_LOOP_BYPASS,
  // Read requests
  input  wire logic                    I_RD_REQ,
  input  wire logic [AW-1:0]           I_RD_ADDR,
  output logic                         O_RD_READY,
  // Read answers
  output logic [BURST_LEN*DW-1:0]      O_RD_DATA,
  output logic                         O_RD_VALID,
  // Write requests
  input  wire logic                    I_WR_REQ,
  input  wire logic [AW-1:0]           I_WR_ADDR,
  input  wire logic [BURST_LEN*DW-1:0] I_WR_DATA,
  input  wire logic [BURST_LEN*BN-1:0] I_WR_BE,
  output logic                         O_WR_READY,
  // Link to the memory
  sram_link_if.ctrl                    LINK
);
  localparam int WW = BURST_LEN * DW;
  localparam int MW = BURST_LEN * BN;

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } ctl_st_e;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ctl_st_e             st;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic                k;
    logic                rd_slot;
    logic [AW-1:0]       addr;
    logic                rd_n;
    logic                wr_n;
    logic [DW-1:0]       d;
    logic [BN-1:0]       be_n;
    logic [WW-1:0]       wstage;
    logic [MW-1:0]       bstage;
    logic [WW-1:0]       wdat;
    logic [MW-1:0]       wbe;
    logic [CT_WSH_W-1:0] wsh;
    logic [DW-1:0]       q_s1;
    logic [DW-1:0]       q_s2;
    logic                vld_s1;
    logic                vld_s2;
    logic [WW-1:0]       acc;
    logic [1:0]          acc_cnt;
    logic [WW-1:0]       rd_data;
    logic                rd_valid;
  } ctl_s;

  ctl_s s_reg;
  ctl_s s_next;
  logic run_fall;
  logic k_link;

  // Link clock falls half a system cycle after this edge
  assign run_fall   = (s_reg.st == ST_RUN) & s_reg.k;
  assign O_RD_READY = run_fall & s_reg.rd_slot;
  assign O_WR_READY = run_fall & ~s_reg.rd_slot;

  always_comb begin
    logic wr_go;
    wr_go  = 1'b0;
    s_next = s_reg;
    // Link clock is the system clock divided by two
    s_next.k = ~s_reg.k;

    unique case (s_reg.st)
      ST_INIT: begin
        s_next.init_cnt = s_reg.init_cnt + 1'b1;
        if (s_reg.init_cnt == INIT_CNT_W'(LINK_RST_CYCLES - 1)) begin
          s_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // selects change one and a half system cycles before the true edge
        if (s_reg.k) begin
          s_next.rd_n    = 1'b1;
          s_next.wr_n    = 1'b1;
          // read and write slots alternate per link cycle
          s_next.rd_slot = ~s_reg.rd_slot;
          if (O_RD_READY & I_RD_REQ) begin
            s_next.rd_n = 1'b0;
            s_next.addr = I_RD_ADDR;
          end
          if (O_WR_READY & I_WR_REQ) begin
            wr_go         = 1'b1;
            s_next.wr_n   = 1'b0;
            s_next.addr   = I_WR_ADDR;
            s_next.wstage = I_WR_DATA;
            s_next.bstage = I_WR_BE;
          end
        end
      end
    endcase

    // beats follow the command by one link cycle, one per half
    s_next.wsh  = {s_reg.wsh[CT_WSH_W-2:0], wr_go};
    s_next.d    = '0;
    s_next.be_n = '1;
    // beat one placed ahead of the true edge
    if (s_reg.wsh[2]) begin
      s_next.wdat = s_reg.wstage;
      s_next.wbe  = s_reg.bstage;
      s_next.d    = s_reg.wstage[0 +: DW];
      s_next.be_n = ~s_reg.bstage[0 +: BN];
    end
    // later beats with their own byte enables
    for (int b = 1; b < BURST_LEN; b++) begin
      if (s_reg.wsh[b+2]) begin
        s_next.d    = s_reg.wdat[b*DW +: DW];
        s_next.be_n = ~s_reg.wbe[b*BN +: BN];
      end
    end

    // Read data pins pass two flops before use
    s_next.q_s1   = LINK.q;
    s_next.q_s2   = s_reg.q_s1;
    s_next.vld_s1 = LINK.read_valid_out;
    s_next.vld_s2 = s_reg.vld_s1;
    // collect four valid beats into one word
    s_next.rd_valid = 1'b0;
    if (s_reg.vld_s2) begin
      s_next.acc[s_reg.acc_cnt*DW +: DW] = s_reg.q_s2;
      s_next.acc_cnt                     = s_reg.acc_cnt + 1'b1;
      if (s_reg.acc_cnt == 2'(BURST_LEN - 1)) begin
        s_next.rd_data                          = s_reg.acc;
        s_next.rd_data[(BURST_LEN-1)*DW +: DW]  = s_reg.q_s2;
        s_next.rd_valid                         = 1'b1;
      end
    end

    if (I_SYS_RST) begin
      s_next          = '0;
      s_next.st       = ST_INIT;
      s_next.rd_n     = 1'b1;
      s_next.wr_n     = 1'b1;
      s_next.be_n     = '1;
      s_next.rd_slot  = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    s_reg <= s_next;
  end

  // Link clock moves on the falling system edge, half a cycle away from
  // the pins it qualifies, so the memory never samples a changing input
  always_ff @(negedge I_CLK_SYS) begin
    k_link <= s_reg.k;
  end

  // ---------------------------------------------------------------
  // Link outputs
  // ---------------------------------------------------------------
  assign LINK.k               = k_link;
  assign LINK.rst             = s_reg.st == ST_INIT;
  assign LINK.loop_off_n      = ~I_LOOP_BYPASS;
  assign LINK.sync_address    = s_reg.addr;
  assign LINK.rd_n            = s_reg.rd_n;
  assign LINK.wr_n            = s_reg.wr_n;
  assign LINK.d               = s_reg.d;
  assign LINK.byte_write_en_n = s_reg.be_n;
  assign O_RD_DATA            = s_reg.rd_data;
  assign O_RD_VALID           = s_reg.rd_valid;

endmodule : sram_burst_ctrl

//--- verification/sram_link_assertions.sv
// Link checker: select spacing, write beat windows, read valid timing and echo clocks
`timescale 1ns/1ps
module sram_link_assertions #(
  parameter int AW = 18,
  parameter int DW = 36,
  parameter int BN = 4
) (
  // Link clock and reset
  input logic          k,
  input logic          rst,
  input logic          loop_off_n,
  // Controller side
  input logic [AW-1:0] sync_address,
  input logic          rd_n,
  input logic          wr_n,
  input logic [DW-1:0] d,
  input logic [BN-1:0] byte_write_en_n,
  // Memory side
  input logic [DW-1:0] q,
  input logic          read_valid_out,
  input logic          echo_clk_true,
  input logic          echo_clk_comp
);
  logic [4:0] rd_hist;
  logic [2:0] wr_hist;
  logic [2:0] rst_pipe = 3'h7;
  logic       in_rst;

  // ---------------------------------------------------------------
  // Command history on true edges
  // ---------------------------------------------------------------
  // Memory sees reset through two flops, so checks stay off a little longer
  assign in_rst = rst | (|rst_pipe);
  always_ff @(posedge k) begin
    rst_pipe <= {rst_pipe[1:0], rst};
    rd_hist  <= rst ? 5'h00 : {rd_hist[3:0], ~rd_n};
    wr_hist  <= rst ? 3'h0 : {wr_hist[1:0], ~wr_n};
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_echo_high: assert property (
    @(negedge k) disable iff (in_rst) echo_clk_true && !echo_clk_comp)
    else $error("echo clocks not high before link clock falls");
  chk_echo_low: assert property (
    @(posedge k) disable iff (in_rst) !echo_clk_true && echo_clk_comp)
    else $error("echo clocks not low before link clock rises");
  chk_valid_odd: assert property (
    @(posedge k) disable iff (in_rst) read_valid_out == (rd_hist[2] | rd_hist[3]))
    else $error("read valid wrong in falling half");
  chk_valid_even: assert property (
    @(negedge k) disable iff (in_rst)
    read_valid_out == (loop_off_n ? (rd_hist[3] | rd_hist[4]) : (rd_hist[2] | rd_hist[3])))
    else $error("read valid wrong in rising half");
  chk_be_idle_true: assert property (
    @(posedge k) disable iff (in_rst) (wr_hist[1:0] == 2'h0) |-> (&byte_write_en_n))
    else $error("byte enable outside write beat on true edge");
  chk_be_idle_comp: assert property (
    @(negedge k) disable iff (in_rst) (wr_hist[2:1] == 2'h0) |-> (&byte_write_en_n))
    else $error("byte enable outside write beat on complement edge");
  chk_wr_spacing: assert property (
    @(posedge k) disable iff (in_rst) !wr_n |=> wr_n)
    else $error("write commands closer than two cycles");
  chk_rd_spacing: assert property (
    @(posedge k) disable iff (in_rst) !rd_n |=> rd_n)
    else $error("read commands closer than two cycles");
  chk_sel_alternate: assert property (
    @(posedge k) disable iff (in_rst) !rd_n |-> wr_n)
    else $error("read and write selected on one edge");
endmodule : sram_link_assertions

//--- verification/tb_top.sv
// Testbench: controller and memory joined over the link, random traffic
`timescale 1ns/1ps
module tb_top
  import sram_link_pkg::*;
;
  localparam int AW = 6;
  localparam int DW = 36;
  localparam int BN = 4;
  localparam int WW = BURST_LEN*DW;
  localparam int BW = BURST_LEN*BN;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  logic          loop_bypass = 1'b0;
  logic          rd_req = 1'b0;
  logic [AW-1:0] rd_addr = '0;
  logic          rd_ready;
  logic [WW-1:0] rd_data;
  logic          rd_valid;
  logic          wr_req = 1'b0;
  logic [AW-1:0] wr_addr = '0;
  logic [WW-1:0] wr_data = '0;
  logic [BW-1:0] wr_be = '0;
  logic          wr_ready;
  logic          mem_bypass;
  int            mismatches = 0;
  int            num_checks = 0;
  int            seed = 32'h4622;
  int            cyc = 0;
  int            rd_cmds = 0;
  int            wr_cmds = 0;
  int            rd_taken = 0;
  int            wr_taken = 0;
  int            last_lat = 0;
  logic [WW-1:0] ref_mem [16];
  logic [WW-1:0] exp_q [$];
  int            take_q [$];

  sram_link_if #(.AW(AW), .DW(DW), .BN(BN)) lnk ();
  sram_burst_ctrl #(.AW(AW), .DW(DW), .BN(BN)) u_sram_burst_ctrl (
    .I_CLK_SYS(clk_sys), .I_SYS_RST(sys_rst), .I_LOOP_BYPASS(loop_bypass),
    .I_RD_REQ(rd_req), .I_RD_ADDR(rd_addr), .O_RD_READY(rd_ready),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
    .I_WR_REQ(wr_req), .I_WR_ADDR(wr_addr), .I_WR_DATA(wr_data), .I_WR_BE(wr_be),
    .O_WR_READY(wr_ready), .LINK(lnk));
  sram_burst_mem #(.AW(AW), .DW(DW), .BN(BN)) u_sram_burst_mem (
    .LINK(lnk), .O_LOOP_BYPASS(mem_bypass));
  sram_link_assertions #(.AW(AW), .DW(DW), .BN(BN)) u_sram_link_assertions (
    .k(lnk.k), .rst(lnk.rst), .loop_off_n(lnk.loop_off_n), .sync_address(lnk.sync_address),
    .rd_n(lnk.rd_n), .wr_n(lnk.wr_n), .d(lnk.d), .byte_write_en_n(lnk.byte_write_en_n),
    .q(lnk.q), .read_valid_out(lnk.read_valid_out), .echo_clk_true(lnk.echo_clk_true),
    .echo_clk_comp(lnk.echo_clk_comp));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Byte i of beat b follows enable bit b*BN+i
  function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_w,
                                          input logic [WW-1:0] new_w, input logic [BW-1:0] be);
    logic [WW-1:0] r;
    r = old_w;
    for (int j = 0; j < WW; j++) if (be[(j/DW)*BN + (j%DW)/(DW/BN)]) r[j] = new_w[j];
    return r;
  endfunction : merge

  function automatic logic [WW-1:0] rnd_word();
    return WW'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction : rnd_word

  task automatic do_write(input int a, input logic [WW-1:0] dt, input logic [BW-1:0] be);
    int n;
    @(negedge clk_sys);
    wr_req = 1'b1;
    wr_addr = AW'(a);
    wr_data = dt;
    wr_be = be;
    for (n = 0; n < 64 && wr_ready !== 1'b1; n++) @(negedge clk_sys);
    if (n == 64) begin mismatches++; complete_run(); end
    ref_mem[a%16] = merge(ref_mem[a%16], dt, be);
    wr_taken++;
    @(negedge clk_sys);
    wr_req = 1'b0;
  endtask : do_write

  task automatic do_read(input int a);
    int n;
    @(negedge clk_sys);
    rd_req = 1'b1;
    rd_addr = AW'(a);
    for (n = 0; n < 64 && rd_ready !== 1'b1; n++) @(negedge clk_sys);
    if (n == 64) begin mismatches++; complete_run(); end
    exp_q.push_back(ref_mem[a%16]);
    take_q.push_back(cyc + 1);
    rd_taken++;
    @(negedge clk_sys);
    rd_req = 1'b0;
  endtask : do_read

  task automatic drain();
    int n;
    for (n = 0; n < 300 && exp_q.size() != 0; n++) @(negedge clk_sys);
    if (n == 300) begin mismatches++; complete_run(); end
  endtask : drain

  // ---------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (sys_rst === 1'b0) check(WW'(lnk.echo_clk_comp), WW'(!lnk.echo_clk_true));
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
      last_lat = cyc - take_q.pop_front();
    end
  end
  always @(posedge lnk.k) begin
    if (lnk.rst === 1'b0 && lnk.rd_n === 1'b0) rd_cmds++;
    if (lnk.rst === 1'b0 && lnk.wr_n === 1'b0) wr_cmds++;
  end
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int norm_lat;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    // Fill every used word, then read all back
    for (int i = 0; i < 16; i++) do_write(i, rnd_word(), {BW{1'b1}});
    for (int i = 0; i < 16; i++) do_read(i);
    drain();
    check(WW'(mem_bypass), WW'(1'b0));
    $display("test fill done");
    // Concurrent partial writes and reads on separate buses
    fork
      for (int i = 0; i < 24; i++) do_write(8 + i%8, rnd_word(), BW'($random(seed)));
      for (int i = 0; i < 24; i++) do_read(($random(seed) & 7));
    join
    for (int i = 8; i < 16; i++) do_read(i);
    drain();
    $display("test concurrent done");
    // Read right behind a write to the same word, enable corners first
    for (int i = 0; i < 6; i++) begin
      do_write(i*3, rnd_word(), i == 0 ? '0 : (i == 1 ? {BW{1'b1}} : BW'($random(seed))));
      do_read(i*3);
    end
    drain();
    norm_lat = last_lat;
    $display("test coherence done");
    // Reset again into reduced latency mode
    @(negedge clk_sys);
    sys_rst = 1'b1;
    loop_bypass = 1'b1;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    do_write(5, rnd_word(), {BW{1'b1}});
    do_read(5);
    drain();
    check(WW'(mem_bypass), WW'(1'b1));
    check(WW'(last_lat), WW'(norm_lat - 1));
    check(WW'(rd_cmds), WW'(rd_taken));
    check(WW'(wr_cmds), WW'(wr_taken));
    $display("test bypass done");
    complete_run();
  end
endmodule : tb_top
